/* rtl/sdc_pkg.sv */
// Purpose: constants and types shared by the memory command controller
// Assumes: one core clock at 40 MHz
// Notes:   command codes are {bank_sel_n, row_n, col_n, write_n}
package sdc_pkg;
    localparam int unsigned CORE_CLK_HZ     = 40_000_000;
    localparam int unsigned MEM_CLK_MAX_HZ  = 100_000_000;
    localparam int unsigned ROW_BITS        = 13;
    localparam int unsigned COL_BITS        = 11;
    localparam int unsigned BANK_BITS       = 2;
    localparam int unsigned ADDR_BITS       = 15;
    localparam int unsigned SEL_BITS        = 4;
    localparam int unsigned TRAS_W          = 4;
    localparam int unsigned T3_W            = 3;
    localparam int unsigned CL_W            = 2;
    localparam int unsigned REF_W           = 16;
    localparam int unsigned CNT_W           = 6;
    localparam int unsigned PG_W            = 2;
    localparam int unsigned ADDR_TEN        = 10;
    localparam int unsigned BANK_LO         = 13;
    localparam logic [CNT_W-1:0] T_MRD      = 6'h02;
    localparam logic [CNT_W-1:0] T_DRD_BASE = 6'h02;
    localparam logic [CNT_W-1:0] T_XSR_BASE = 6'h02;
    localparam logic [CNT_W-1:0] CNT_ONE    = 6'h01;
    localparam logic [3:0] CMD_MODE_SET     = 4'h0;
    localparam logic [3:0] CMD_ACTIVATE     = 4'h3;
    localparam logic [3:0] CMD_PRECHARGE    = 4'h2;
    localparam logic [3:0] CMD_REFRESH      = 4'h1;
    localparam logic [3:0] CMD_READ         = 4'h5;
    localparam logic [3:0] CMD_WRITE        = 4'h4;
    localparam logic [3:0] CMD_DESELECT     = 4'hf;
    localparam logic [3:0] CMD_SELF_REFRESH_COMMAND_ENTRY   = 4'h1;
    // burst length one, sequential, latency in bits 5:4
    localparam logic [ADDR_BITS-1:0] MODE_BASE = 15'h0000;
    localparam int unsigned MODE_CL_LO      = 4;

    typedef enum logic [3:0] {
        SDC_MODE, SDC_MODE_WAIT, SDC_IDLE, SDC_PRECHG, SDC_ACT,
        SDC_RW, SDC_DUMMY, SDC_REFRESH, SDC_SELF_REFRESH_COMMAND, SDC_SELF_REFRESH_COMMAND_EXIT, SDC_WAIT
    } sdc_state_t;
endpackage : sdc_pkg

/* rtl/sdc_command_controller.sv */
// Purpose: converts core request strobes into pulsed memory commands
// Assumes: one clock, memory clock derived by enable; one request at a time
// Notes:   row held open until off-page, refresh or self refresh
// Summary of operation
// (RULE1) command interface runs on memory clock, at most 100 MHz
// (RULE2) core request strobes become pulsed standard memory commands
// (RULE3) acknowledge withheld during activate, precharge and refresh overhead
// (RULE4) act only when address bank is assigned to memory
// (RULE5) one outstanding address; next access never overlaps current
// (RULE6) first access multiplexes row then column; 13 row, 11 column lines
// (RULE7) bank number driven on address lines 14 and 13
// (RULE8) divider gives memory clock at full or half core rate
// (RULE9) command and address logic independent of data width
// (RULE10) page sizes 256, 512, 1024, 2048 words supported
// (RULE11) mode set, activate, precharge all, refresh strobe encodings
// (RULE12) read 1,0,1; write 1,0,0 with address ten low; deselect
// (RULE13) self refresh entry drops clock enable; exit with deselect
// (RULE14) commands sampled on memory clock, clock enable may change freely
// (RULE15) no power down, clock suspend or auto precharge issued
// (RULE16) timing fields and fixed dummy read, mode, exit times
// (RULE17) commands, addresses and data captured on rising memory clock
// (RULE18) rate bit set gives full core rate, cleared half rate
// (RULE19) memory clock driven only for processor id 0 or 1, or sync flag
// (RULE20) bus clock depends only on input clock and doubling pin
// (RULE21) interface sampled with core clock cycles
// (RULE22) wait, refresh count and control settings configure interface
// (RULE23) mode register gets burst length one, sequential type
// (RULE24) data mask high during mode set and precharge all only
// (RULE25) two banks use line 14; four use 13 and 14
// (RULE26) open row kept until off-page, refresh or self refresh
`timescale 1ns/1ps
module sdc_command_controller
    import sdc_pkg::*;
#(
    parameter int unsigned ADDR_W = 24
)(
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_req,
    input  wire logic                  i_we,
    input  wire logic [ADDR_W-1:0]     i_addr,
    input  wire logic [SEL_BITS-1:0]   i_bank_hit,
    input  wire logic [SEL_BITS-1:0]   i_bank_enable,
    input  wire logic                  i_mem_clock_rate_bit,
    input  wire logic                  i_clock_doubling_pin_n,
    input  wire logic [2:0]            i_proc_id,
    input  wire logic                  i_bus_sync_flag,
    input  wire logic [TRAS_W-1:0]     i_tras,
    input  wire logic [T3_W-1:0]       i_trcd,
    input  wire logic [T3_W-1:0]       i_trp,
    input  wire logic [CL_W-1:0]       i_cas_latency,
    input  wire logic [PG_W-1:0]       i_page_size,
    input  wire logic                  i_four_banks,
    input  wire logic [REF_W-1:0]      i_refresh_count_register, // see RULE22
    input  wire logic                  i_self_refresh_req,
    output logic                       o_ack,
    output logic                       o_mem_clock_out,
    output logic                       o_mem_clock_oe,
    output logic                       o_external_bus_clock,
    output logic                       o_mem_clock_enable_line,
    output logic [SEL_BITS-1:0]        o_bank_select_lines_n,
    output logic                       o_row_strobe_n,
    output logic                       o_col_strobe_n,
    output logic                       o_mem_write_strobe_n,
    output logic [ADDR_BITS-1:0]       o_addr,
    output logic                       o_dqm,
    output logic                       o_in_self_refresh
);
    sdc_state_t state_ff, nxt_state;
    logic              clk_div_ff, dbl_meta_ff, dbl_ff, bus_div_ff;
    logic              mclk_en;
    logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
    logic [REF_W-1:0]  ref_ff;
    logic              ref_pend_ff, row_open_ff, we_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] open_ff;
    logic [3:0]        cmd_ff, nxt_cmd;
    logic [ADDR_BITS-1:0] maddr_ff, nxt_maddr;
    logic              cke_ff, nxt_cke, ack_ff, nxt_ack;
    logic [SEL_BITS-1:0] sel_ff, nxt_sel;

    // full rate when rate bit set, else half rate enable (see RULE8) (see RULE18) (see RULE1)
    assign mclk_en = i_mem_clock_rate_bit | clk_div_ff;
    // half rate rises midway between command updates (see RULE17) (see RULE14)
    assign o_mem_clock_out = i_mem_clock_rate_bit ? i_clk : clk_div_ff;

    // column width follows page size 256..2048 (see RULE10) (see RULE9)
    wire [COL_BITS-1:0] col_mask = COL_BITS'((11'h100 << i_page_size) - 11'h001);
    wire [COL_BITS-1:0] col_addr = addr_ff[COL_BITS-1:0] & col_mask;
    wire [1:0] bank_w = i_four_banks ? 2'h2 : 2'h1;
    wire [ROW_BITS-1:0] row_addr = ROW_BITS'(addr_ff >> (8 + i_page_size + bank_w));
    // bank bits sit just above the column, so consecutive pages rotate banks
    wire [BANK_BITS-1:0] bank_raw = BANK_BITS'(addr_ff >> (8 + i_page_size));
    // two banks use only line 14 (see RULE25) (see RULE7)
    wire [BANK_BITS-1:0] bank = i_four_banks ? bank_raw : {bank_raw[0], 1'b0};
    wire hit = |(i_bank_hit & i_bank_enable);                       // see RULE4
    wire same_page = row_open_ff &&
                     ((i_addr >> (8 + i_page_size)) == (open_ff >> (8 + i_page_size))); // see RULE26
    wire [ADDR_BITS-1:0] row_word = {bank, ROW_BITS'(0)} | ADDR_BITS'(row_addr);
    // column bit 10 moves to line 11, line 10 stays low for read and write
    wire [ADDR_BITS-1:0] col_word = {bank, ROW_BITS'(0)}
                                    | ADDR_BITS'({col_addr[COL_BITS-1], 1'b0, col_addr[ADDR_TEN-1:0]}); // see RULE12 (see RULE15)
    wire [ADDR_BITS-1:0] mode_word = MODE_BASE | (ADDR_BITS'(i_cas_latency) << MODE_CL_LO); // see RULE23
    wire [CNT_W-1:0] t_trc = CNT_W'(i_tras) + CNT_W'(i_trp);
    wire [CNT_W-1:0] t_drd = T_DRD_BASE + CNT_W'(i_cas_latency);   // see RULE16
    wire ref_due = (ref_ff == '0);
    wire clk_allowed = (i_proc_id <= 3'h1) | i_bus_sync_flag;      // see RULE19

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            clk_div_ff  <= 1'b0;
            dbl_meta_ff <= 1'b1;
            dbl_ff      <= 1'b1;
            bus_div_ff  <= 1'b0;
            o_mem_clock_oe       <= 1'b0;
            o_external_bus_clock <= 1'b0;
        end
        else
        begin
            clk_div_ff  <= ~clk_div_ff;
            dbl_meta_ff <= i_clock_doubling_pin_n;
            dbl_ff      <= dbl_meta_ff;
            bus_div_ff  <= ~bus_div_ff;
            o_mem_clock_oe       <= clk_allowed;                    // see RULE19
            // bus clock from input clock and doubling pin only, slower when doubled (see RULE20)
            o_external_bus_clock <= dbl_ff ? ~o_external_bus_clock : (o_external_bus_clock ^ bus_div_ff);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ref_ff <= '1;
        else if (mclk_en)
            ref_ff <= (ref_due || state_ff == SDC_REFRESH || state_ff == SDC_MODE) ?
                      i_refresh_count_register : ref_ff - 1'b1;     // see RULE16
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        nxt_cmd   = CMD_DESELECT;
        nxt_sel   = '1;
        nxt_maddr = maddr_ff;
        nxt_cke   = cke_ff;
        nxt_ack   = 1'b0;
        case (state_ff)
            SDC_MODE:
            begin
                nxt_cmd   = CMD_MODE_SET;                           // see RULE11
                nxt_sel   = '0;
                nxt_maddr = mode_word;
                nxt_cnt   = T_MRD;
                nxt_state = SDC_WAIT;
            end
            SDC_IDLE:
            begin
                if (ref_pend_ff || i_self_refresh_req)
                    nxt_state = row_open_ff ? SDC_PRECHG : (i_self_refresh_req ? SDC_SELF_REFRESH_COMMAND : SDC_REFRESH);
                else if (i_req && hit && !o_ack)                    // see RULE5
                    nxt_state = same_page ? SDC_RW : (row_open_ff ? SDC_PRECHG : SDC_ACT); // see RULE26
            end
            SDC_PRECHG:
            begin
                nxt_cmd   = CMD_PRECHARGE;                          // see RULE11 (see RULE3)
                nxt_sel   = '0;
                nxt_maddr = ADDR_BITS'(1) << ADDR_TEN;              // see RULE11
                nxt_cnt   = CNT_W'(i_trp);
                nxt_state = SDC_WAIT;
            end
            SDC_ACT:
            begin
                nxt_cmd   = CMD_ACTIVATE;                           // see RULE6 (see RULE11)
                nxt_sel   = '0;
                nxt_maddr = row_word;
                nxt_cnt   = CNT_W'(i_trcd);
                nxt_state = SDC_WAIT;
            end
            SDC_RW:
            begin
                nxt_cmd   = we_ff ? CMD_WRITE : CMD_READ;           // see RULE12 (see RULE2)
                nxt_sel   = '0;
                nxt_maddr = col_word;
                nxt_ack   = we_ff;
                nxt_cnt   = t_drd;
                nxt_state = we_ff ? SDC_IDLE : SDC_DUMMY;
            end
            SDC_DUMMY:
            begin
                if (cnt_ff <= CNT_ONE)
                begin
                    nxt_ack   = 1'b1;
                    nxt_state = SDC_IDLE;
                end
            end
            SDC_REFRESH:
            begin
                nxt_cmd   = CMD_REFRESH;                            // see RULE11 (see RULE3)
                nxt_sel   = '0;
                nxt_cnt   = t_trc;
                nxt_state = SDC_WAIT;
            end
            SDC_SELF_REFRESH_COMMAND:
            begin
                if (cke_ff)
                begin
                    nxt_cmd = CMD_SELF_REFRESH_COMMAND_ENTRY;                       // see RULE13
                    nxt_sel = '0;
                    nxt_cke = 1'b0;
                end
                else if (!i_self_refresh_req)
                begin
                    nxt_cke   = 1'b1;                               // see RULE13
                    nxt_cnt   = T_XSR_BASE + t_trc;                 // see RULE16
                    nxt_state = SDC_WAIT;
                end
            end
            SDC_WAIT:
            begin
                if (cnt_ff <= CNT_ONE)
                    nxt_state = SDC_IDLE;
            end
            default:
                nxt_state = SDC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_ff    <= SDC_MODE;
            cnt_ff      <= '0;
            cmd_ff      <= CMD_DESELECT;
            sel_ff      <= '1;
            maddr_ff    <= '0;
            cke_ff      <= 1'b1;
            ack_ff      <= 1'b0;
            ref_pend_ff <= 1'b0;
            row_open_ff <= 1'b0;
            we_ff       <= 1'b0;
            addr_ff     <= '0;
            open_ff     <= '0;
        end
        else if (mclk_en)                                           // see RULE21
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            cmd_ff   <= nxt_cmd;
            sel_ff   <= nxt_sel;
            maddr_ff <= nxt_maddr;
            cke_ff   <= nxt_cke;
            ack_ff   <= nxt_ack;
            // set wins over clear of a pending refresh
            ref_pend_ff <= ref_due | (ref_pend_ff & (state_ff != SDC_REFRESH));
            if (state_ff == SDC_IDLE && i_req && hit && !o_ack)
            begin
                addr_ff <= i_addr;
                we_ff   <= i_we;
            end
            if (state_ff == SDC_ACT)
            begin
                row_open_ff <= 1'b1;
                open_ff     <= addr_ff;
            end
            else if (state_ff == SDC_PRECHG)
                row_open_ff <= 1'b0;
        end
        else
            ack_ff <= 1'b0;
    end

    assign o_ack                   = ack_ff;                        // see RULE3
    assign o_mem_clock_enable_line = cke_ff;
    assign o_bank_select_lines_n   = sel_ff | {SEL_BITS{cmd_ff[3]}};
    assign o_row_strobe_n          = cmd_ff[2];
    assign o_col_strobe_n          = cmd_ff[1];
    assign o_mem_write_strobe_n    = cmd_ff[0];
    assign o_addr                  = maddr_ff;
    assign o_dqm                   = (sel_ff == '0) &&
                                     (cmd_ff == CMD_MODE_SET || cmd_ff == CMD_PRECHARGE); // see RULE24
    assign o_in_self_refresh       = ~cke_ff;

    AST_DQM_ONLY_MS_PRE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE24
        o_dqm |-> (o_row_strobe_n == 1'b0 && o_mem_write_strobe_n == 1'b0))
        else $error("mask high outside mode set or precharge");
    AST_READ_ADDR_TEN_LOW: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE12
        (o_bank_select_lines_n == '0 && o_row_strobe_n && !o_col_strobe_n) |-> !o_addr[ADDR_TEN])
        else $error("read or write with address ten high");
    AST_PRE_ADDR_TEN_HIGH: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE11
        (o_bank_select_lines_n == '0 && !o_row_strobe_n && o_col_strobe_n && !o_mem_write_strobe_n)
        |-> o_addr[ADDR_TEN])
        else $error("precharge without address ten");
    AST_CLK_OE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE19
        (i_proc_id > 3'h1 && !i_bus_sync_flag) |=> !o_mem_clock_oe)
        else $error("memory clock driven in multiprocessor case");
    AST_SELF_REFRESH_COMMAND_ENTRY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE13
        $fell(o_mem_clock_enable_line) |-> (o_bank_select_lines_n == '0 && !o_row_strobe_n
        && !o_col_strobe_n && o_mem_write_strobe_n))
        else $error("bad self refresh entry");
    AST_SELF_REFRESH_COMMAND_EXIT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE13
        $rose(o_mem_clock_enable_line) |-> o_bank_select_lines_n == '1)
        else $error("self refresh exit not deselected");
    AST_NO_ACK_IN_OVERHEAD: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE3
        (state_ff == SDC_PRECHG || state_ff == SDC_ACT || state_ff == SDC_REFRESH) |-> !o_ack)
        else $error("acknowledge during overhead");
    AST_FULL_RATE: assert property (@(negedge i_clk) disable iff (!i_reset_n) // see RULE18
        (i_mem_clock_rate_bit && $past(i_mem_clock_rate_bit)) |-> o_mem_clock_out)
        else $error("memory clock not at core rate");
    COV_WRITE: cover property (@(posedge i_clk) disable iff (!i_reset_n) state_ff == SDC_RW && we_ff);
    COV_READ: cover property (@(posedge i_clk) disable iff (!i_reset_n) state_ff == SDC_DUMMY ##1 o_ack);
    COV_REFRESH: cover property (@(posedge i_clk) disable iff (!i_reset_n) state_ff == SDC_REFRESH);
    COV_SELF_REFRESH_COMMAND: cover property (@(posedge i_clk) disable iff (!i_reset_n) $fell(o_mem_clock_enable_line));
endmodule : sdc_command_controller

/* testbench/sdc_mem_model.sv */
// Purpose: behavioural memory that decodes controller commands
// Assumes: commands latched on the rising memory clock
// Notes:   counts commands per code and flags protocol breaks
`timescale 1ns/1ps
module sdc_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_mem_clk,
    input  wire logic        i_cke,
    input  wire logic [3:0]  i_sel_n,
    input  wire logic        i_ras_n,
    input  wire logic        i_cas_n,
    input  wire logic        i_we_n,
    input  wire logic [14:0] i_addr,
    input  wire logic        i_dqm
);
    logic [23:0] pre;
    logic        cke_q;
    logic        row_open;
    logic [2:0]  cmd;
    int          cnt [0:8];
    logic [14:0] adr [0:8];
    logic        dq  [0:8];
    int          err_count;

    // snapshot before the edge, so the memory sees what stood before it
    always @(posedge i_clk) pre = {i_cke, i_sel_n, i_ras_n, i_cas_n, i_we_n, i_addr, i_dqm};

    always @(posedge i_mem_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cke_q = 1'b1;
            row_open = 1'b0;
            err_count = 0;
            for (int k = 0; k < 9; k++) cnt[k] = 0;
        end
        else
        begin
            cmd = pre[18:16];
            if (cke_q && pre[23] && pre[22:19] == 4'h0)
            begin
                cnt[cmd] += 1;
                adr[cmd] = pre[15:1];
                dq[cmd] = pre[0];
                if ((cmd == 3'h3 || cmd == 3'h1) && row_open) err_count += 1;
                if ((cmd == 3'h4 || cmd == 3'h5) && (!row_open || pre[11])) err_count += 1;
                if (cmd == 3'h3) row_open = 1'b1;
                if (cmd == 3'h2) row_open = 1'b0;
            end
            if (cke_q && !pre[23])
            begin
                cnt[8] += 1;
                if (pre[22:19] != 4'h0 || cmd != 3'h1 || row_open) err_count += 1;
            end
            if (!cke_q && pre[23] && pre[22:19] != 4'hf) err_count += 1;
            cke_q = pre[23];
        end
    end
endmodule : sdc_mem_model

/* testbench/sdc_command_controller_tb.sv */
// Purpose: self-checking bench for the memory command controller
// Assumes: half-rate memory clock for command checks, 256-word pages except 512-word pages for the two-bank access
// Notes:   memory side is a behavioural command decoder
`timescale 1ns/1ps
module sdc_command_controller_tb;
    import sdc_pkg::*;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_req = 1'b0, i_we = 1'b0, i_rate = 1'b0, i_sync = 1'b0;
    logic i_self_refresh_command = 1'b0;
    logic [23:0] i_addr = 24'h000000;
    logic [3:0]  i_hit = 4'h2;
    logic [2:0]  i_id = 3'h0;
    logic [3:0]  i_en = 4'h2;
    logic [1:0]  i_pg = 2'h0;
    logic i_dbl = 1'b1, i_banks4 = 1'b1;
    logic o_ack, o_mclk, o_oe, o_bclk, o_cke, o_ras_n, o_cas_n, o_we_n, o_dqm, o_sr;
    logic [3:0]  o_sel_n;
    logic [14:0] o_addr;
    int bad_count = 0, checks = 0, mclk_n = 0, bclk_n = 0;

    always #12.5 i_clk = ~i_clk;
    always @(posedge o_mclk) mclk_n++;
    always @(posedge o_bclk) bclk_n++;

    sdc_command_controller dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_we(i_we),
        .i_addr(i_addr), .i_bank_hit(i_hit), .i_bank_enable(i_en), .i_mem_clock_rate_bit(i_rate),
        .i_clock_doubling_pin_n(i_dbl), .i_proc_id(i_id), .i_bus_sync_flag(i_sync), .i_tras(4'h3),
        .i_trcd(3'h2), .i_trp(3'h2), .i_cas_latency(2'h2), .i_page_size(i_pg), .i_four_banks(i_banks4),
        .i_refresh_count_register(16'h0400), .i_self_refresh_req(i_self_refresh_command), .o_ack(o_ack),
        .o_mem_clock_out(o_mclk), .o_mem_clock_oe(o_oe), .o_external_bus_clock(o_bclk),
        .o_mem_clock_enable_line(o_cke), .o_bank_select_lines_n(o_sel_n), .o_row_strobe_n(o_ras_n),
        .o_col_strobe_n(o_cas_n), .o_mem_write_strobe_n(o_we_n), .o_addr(o_addr), .o_dqm(o_dqm),
        .o_in_self_refresh(o_sr));

    sdc_mem_model mem (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_mem_clk(o_mclk), .i_cke(o_cke),
        .i_sel_n(o_sel_n), .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_addr(o_addr),
        .i_dqm(o_dqm));

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_flag(input logic ok);
        checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("FAIL %0t condition false", $time);
        end
    endtask : check_flag

    task automatic complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // counts acks over a span; the request stays as the caller left it
    task automatic count_acks(input int span, output int n);
        n = 0;
        repeat (span)
        begin
            @(posedge i_clk);
            #1;
            if (o_ack === 1'b1) n++;
        end
    endtask : count_acks

    task automatic access(input logic we, input logic [23:0] adr, output int lat);
        int extra;
        lat = -1;
        @(posedge i_clk);
        #1;
        i_we = we;
        i_addr = adr;
        i_req = 1'b1;
        for (int n = 0; n < 200; n++)
        begin
            @(posedge i_clk);
            #1;
            if (o_ack === 1'b1)
            begin
                lat = n;
                break;
            end
        end
        i_req = 1'b0;
        check_flag(lat >= 0);
        count_acks(6, extra);
        check_val(extra, 0);
    endtask : access

    task automatic wait_self_refresh_command(input logic v);
        for (int n = 0; n < 400 && o_sr !== v; n++) @(posedge i_clk);
        check_val(o_sr, v);
    endtask : wait_self_refresh_command

    task automatic rate_run(input logic rate, input int exp, output int bus);
        int m0, b0;
        @(posedge i_clk);
        #1 i_rate = rate;
        repeat (8) @(posedge i_clk);
        m0 = mclk_n;
        b0 = bclk_n;
        repeat (40) @(posedge i_clk);
        check_flag(mclk_n - m0 >= exp - 1 && mclk_n - m0 <= exp + 1);
        bus = bclk_n - b0;
    endtask : rate_run

    initial
    begin
        int lc, lo, lat, n, b0, b1;
        repeat (10) @(posedge i_clk);
        check_val(o_sel_n, 4'hf);
        check_val(o_cke, 1'b1);
        check_val(o_ack, 1'b0);
        repeat (10) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        repeat (40) @(posedge i_clk);
        check_val(mem.cnt[0], 1);
        check_val(mem.adr[0], MODE_BASE | (15'h0002 << MODE_CL_LO));
        check_val(mem.dq[0], 1'b1);
        check_val(o_oe, 1'b1);
        // region 0 is not mapped to memory, then region 1 is disabled
        #1;
        i_hit = 4'h1;
        i_req = 1'b1;
        count_acks(20, n);
        i_hit = 4'h2;
        i_en = 4'h1;
        count_acks(20, lo);
        i_req = 1'b0;
        i_en = 4'h2;
        check_val(n + lo, 0);
        check_val(mem.cnt[3], 0);
        access(1'b1, 24'h012345, lc);
        check_val(mem.cnt[3], 1);
        check_val(mem.adr[3], 15'h6048);
        check_val(mem.dq[3], 1'b0);
        check_val(mem.adr[4], 15'h6045);
        check_val(mem.dq[4], 1'b0);
        access(1'b1, 24'h012346, lo);
        check_val(mem.cnt[3], 1);
        check_val(mem.cnt[4], 2);
        check_flag(lo < lc);
        access(1'b0, 24'h012347, lat);
        check_val(mem.cnt[5], 1);
        check_val(mem.adr[5], 15'h6047);
        access(1'b1, 24'h012745, lat);
        check_val(mem.cnt[2], 1);
        check_flag(mem.adr[2][10] === 1'b1 && mem.dq[2] === 1'b1);
        check_val(mem.cnt[3], 2);
        repeat (2600) @(posedge i_clk);
        check_val(mem.cnt[1], 1);
        check_val(mem.cnt[2], 2);
        access(1'b1, 24'h012745, lat);
        check_val(mem.cnt[3], 3);
        #1 i_self_refresh_command = 1'b1;
        wait_self_refresh_command(1'b1);
        repeat (4) @(posedge i_clk);
        check_val(mem.cnt[8], 1);
        check_val(o_cke, 1'b0);
        check_val(mem.cnt[2], 3);
        #1 i_self_refresh_command = 1'b0;
        wait_self_refresh_command(1'b0);
        repeat (10) @(posedge i_clk);
        check_val(o_cke, 1'b1);
        #1;
        i_banks4 = 1'b0;
        i_pg = 2'h1;
        access(1'b1, 24'h012345, lat);
        check_val(mem.adr[3], 15'h4048);
        check_val(mem.adr[4], 15'h4145);
        check_val(mem.err_count, 0);
        rate_run(1'b0, 20, b0);
        rate_run(1'b1, 40, b1);
        check_flag(b0 - b1 >= -1 && b0 - b1 <= 1);
        #1 i_dbl = 1'b0;
        rate_run(1'b0, 20, b1);
        check_flag(b1 >= 9 && b1 <= 11);
        #1 i_id = 3'h2;
        repeat (6) @(posedge i_clk);
        check_val(o_oe, 1'b0);
        #1 i_sync = 1'b1;
        repeat (6) @(posedge i_clk);
        check_val(o_oe, 1'b1);
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        complete_run();
    end
endmodule : sdc_command_controller_tb
